// file: rtl/otp_pkg.sv
// Shared constants, modes, pin bundles and mode decode for the OTP write/verify block.
// Assumes a single 100 MHz clock and pins already synchronous to it.
package otp_pkg;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int unsigned CLK_PERIOD_NS = 10;
    localparam int unsigned RESET_HOLD_NS = 10000;
    localparam int unsigned RESET_HOLD_CYC = (RESET_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned HOLD_CNT_W = 10;
    localparam logic [HOLD_CNT_W-1:0] RESET_HOLD_LAST = HOLD_CNT_W'(RESET_HOLD_CYC - 1);

    // ------------------------------------------------------------
    // Memory and pin geometry
    // ------------------------------------------------------------
    localparam int unsigned MEM_WORDS = 512;
    localparam int unsigned MEM_DATA_W = 16;
    localparam int unsigned MEM_ADDR_W = 9;
    localparam int unsigned PIN_DATA_W = 8;
    localparam int unsigned MODE_W = 4;
    localparam int unsigned OB_W = 3;
    localparam int unsigned PHASE_W = 2;
    localparam int unsigned PHASE_HALF_BIT = 1;
    localparam logic [PHASE_W-1:0] PHASE_LAST = 2'h3;
    localparam logic [1:0] BE_LOW = 2'h1;
    localparam logic [1:0] BE_HIGH = 2'h2;

    // ------------------------------------------------------------
    // Mode-select patterns, bit 0 = mode_sel_0
    // ------------------------------------------------------------
    localparam logic [MODE_W-1:0] PAT_CLEAR = 4'h5;
    localparam logic [MODE_W-1:0] PAT_WRITE = 4'hE;
    localparam logic [MODE_W-1:0] PAT_VERIFY = 4'hC;
    localparam logic [MODE_W-1:0] PAT_INHIBIT = 4'hD;
    localparam logic [MODE_W-1:0] MASK_INHIBIT = 4'hD;

    // ------------------------------------------------------------
    // Register map (byte addresses)
    // ------------------------------------------------------------
    localparam int unsigned AVS_ADDR_W = 4;
    localparam logic [AVS_ADDR_W-1:0] REG_CTRL = 4'h0;
    localparam logic [AVS_ADDR_W-1:0] REG_STATUS = 4'h4;
    localparam logic [AVS_ADDR_W-1:0] REG_WRCNT = 4'h8;
    localparam int unsigned CTRL_ALLOW_BIT = 0;
    localparam logic CTRL_ALLOW_RST = 1'h1;
    localparam int unsigned WRCNT_W = 16;

    typedef enum logic [4:0] {
        MODE_NONE = 5'h01,
        MODE_CLEAR = 5'h02,
        MODE_WRITE = 5'h04,
        MODE_VERIFY = 5'h08,
        MODE_INHIBIT = 5'h10
    } otp_mode_e;

    typedef enum logic [2:0] {
        S_NORMAL = 3'h1,
        S_RESET = 3'h2,
        S_PROG = 3'h4
    } otp_sess_e;

    typedef struct packed {
        logic [MODE_W-1:0] mode_sel;
        logic osc_in_pin;
        logic rst_pin_low;
        logic vpp_prog;
        logic vdd_prog;
        logic [PIN_DATA_W-1:0] data_in;
    } otp_pin_in_s;

    typedef struct packed {
        logic [OB_W-1:0] port_ob_out;
        logic [OB_W-1:0] port_ob_oe;
        logic [PIN_DATA_W-1:0] data_out;
        logic [PIN_DATA_W-1:0] data_oe;
    } otp_pin_out_s;

    function automatic otp_mode_e otp_decode_mode(input logic [MODE_W-1:0] sel);
        otp_mode_e m;
        m = MODE_NONE;
        if (sel == PAT_CLEAR) begin
            m = MODE_CLEAR;
        end else if (sel == PAT_WRITE) begin
            m = MODE_WRITE;
        end else if (sel == PAT_VERIFY) begin
            m = MODE_VERIFY;
        end else if ((sel & MASK_INHIBIT) == PAT_INHIBIT) begin
            m = MODE_INHIBIT;
        end
        return m;
    endfunction : otp_decode_mode

endpackage : otp_pkg

// file: rtl/otp_mem.sv
// Program memory array with two byte lanes and registered read data.
// Assumes the caller gates writes; clock enable freezes the read register.
`timescale 1ns/1ps
`default_nettype none
module otp_mem #(
    parameter int unsigned WORDS = 512,
    parameter int unsigned DATA_W = 16,
    parameter int unsigned ADDR_W = 9
) (
    // Clock
    input wire logic clock,
    input wire logic ce,
    // Access
    input wire logic we,
    input wire logic [1:0] be,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [DATA_W-1:0] wdata,
    output logic [DATA_W-1:0] rdata_r
);
    localparam int unsigned LANE_W = DATA_W / 2;

    logic [DATA_W-1:0] mem [WORDS];

    always_ff @(posedge clock) begin
        if (ce) begin
            for (int i = 0; i < 2; i++) begin
                if (we && be[i]) begin
                    mem[addr][i*LANE_W +: LANE_W] <= wdata[i*LANE_W +: LANE_W];
                end
            end
            rdata_r <= mem[addr];
        end
    end

endmodule : otp_mem
`default_nettype wire

// file: rtl/otp_pulse_div.sv
// Counts rising edges of the oscillator input pin in groups of four.
// Assumes the pin is already synchronous to clock.
`timescale 1ns/1ps
`default_nettype none
module otp_pulse_div
    import otp_pkg::*;
#(
    parameter int unsigned PW = PHASE_W
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rst_n,
    input wire logic ce,
    // Control
    input wire logic osc_in_pin,
    input wire logic clr,
    input wire logic adv_en,
    // Result
    output logic [PW-1:0] phase_r,
    output logic step_r
);
    logic osc_prev_r;
    logic rise;

    assign rise = osc_in_pin && !osc_prev_r;

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            osc_prev_r <= 1'b0;
        end else if (ce) begin
            osc_prev_r <= osc_in_pin;
        end
    end

    // Phase within the four-pulse cycle; fourth pulse yields one step
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            phase_r <= '0;
            step_r <= 1'b0;
        end else if (ce) begin
            step_r <= 1'b0;
            if (clr) begin
                phase_r <= '0;
            end else if (rise) begin
                phase_r <= phase_r + PW'(1);
                step_r <= adv_en && (phase_r == PHASE_LAST);
            end
        end
    end

endmodule : otp_pulse_div
`default_nettype wire

// file: rtl/otp_prog_top.sv
// OTP program memory write/verify logic with its Avalon-MM register slave.
// Assumes pins are synchronous to clock; voltage levels arrive as digital flags.
//
// Contract
// - Enter write/verify only after reset hold, then raised supply and programming voltage.
// - Mode pins decode clear, write, verify and inhibit with the given patterns.
// - In write/verify, port OB bits 0-2 and oscillator output are mode inputs.
// - No address pins; internal counter advanced only by oscillator input pulses.
// - Counter steps once per four oscillator pulses in program inhibit mode.
// - Verify drives memory onto data pins, one address per four pulses.
// - Eight-bit data bus: low nibble on port OD, high nibble on port OC.
//
// Register access over Avalon-MM and the register addresses were decided locally.
`timescale 1ns/1ps
`default_nettype none
module otp_prog_top
    import otp_pkg::*;
#(
    parameter int unsigned WORDS = MEM_WORDS,
    parameter int unsigned ADDR_W = MEM_ADDR_W
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rst_n,
    input wire logic ce,
    // Avalon-MM slave
    input wire logic [AVS_ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // Device pins
    input wire otp_pin_in_s pins_i,
    output otp_pin_out_s pins_o,
    // Normal port drive from the core
    input wire otp_pin_out_s core_pins_i,
    // Status
    output logic prog_active
);

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    otp_sess_e sess_r;
    otp_sess_e sess_nxt;
    otp_mode_e mode_r;
    otp_mode_e mode_prev_r;
    logic [HOLD_CNT_W-1:0] hold_cnt_r;
    logic hold_done_r;
    logic [ADDR_W-1:0] addr_r;
    logic [PHASE_W-1:0] phase;
    logic step;
    logic in_prog;
    logic pulse_clr;
    logic pulse_adv;
    logic mem_we;
    logic [1:0] mem_be;
    logic [MEM_DATA_W-1:0] mem_rdata;
    logic allow_r;
    logic [WRCNT_W-1:0] wrcnt_r;
    logic wr_entry;
    logic wrcnt_clr;
    logic waitreq_r;
    logic [31:0] rdata_r;
    otp_pin_out_s pins_r;
    logic prog_active_r;
    logic bus_req;
    logic bus_done;

    assign in_prog = (sess_r == S_PROG);
    assign bus_req = avs_read || avs_write;
    assign bus_done = bus_req && !waitreq_r;

    // ------------------------------------------------------------
    // Session entry and exit
    // ------------------------------------------------------------
    always_comb begin
        sess_nxt = sess_r;
        case (sess_r)
            S_NORMAL: begin
                if (pins_i.rst_pin_low) begin
                    sess_nxt = S_RESET;
                end
            end
            S_RESET: begin
                if (hold_done_r && pins_i.vpp_prog && pins_i.vdd_prog && allow_r) begin
                    sess_nxt = S_PROG;
                end else if (!pins_i.rst_pin_low && !hold_done_r) begin
                    sess_nxt = S_NORMAL;
                end
            end
            S_PROG: begin
                if (pins_i.rst_pin_low) begin
                    sess_nxt = S_RESET;
                end else if (!pins_i.vpp_prog) begin
                    sess_nxt = S_NORMAL;
                end
            end
            default: begin
                sess_nxt = S_NORMAL;
            end
        endcase
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            sess_r <= S_NORMAL;
        end else if (ce) begin
            sess_r <= sess_nxt;
        end
    end

    // Time spent with the reset pin low
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            hold_cnt_r <= '0;
            hold_done_r <= 1'b0;
        end else if (ce) begin
            if (sess_r == S_RESET && pins_i.rst_pin_low) begin
                if (hold_cnt_r == RESET_HOLD_LAST) begin
                    hold_done_r <= 1'b1;
                end else begin
                    hold_cnt_r <= hold_cnt_r + HOLD_CNT_W'(1);
                end
            end else if (sess_r != S_RESET) begin
                hold_cnt_r <= '0;
                hold_done_r <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // Mode decode
    // ------------------------------------------------------------
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            mode_r <= MODE_NONE;
            mode_prev_r <= MODE_NONE;
        end else if (ce) begin
            mode_prev_r <= mode_r;
            if (in_prog) begin
                mode_r <= otp_decode_mode(pins_i.mode_sel);
            end else begin
                mode_r <= MODE_NONE;
            end
        end
    end

    // ------------------------------------------------------------
    // Address counter and pulse grouping
    // ------------------------------------------------------------
    assign pulse_clr = !in_prog || (mode_r == MODE_CLEAR);
    assign pulse_adv = in_prog && ((mode_r == MODE_INHIBIT) || (mode_r == MODE_VERIFY));

    otp_pulse_div u_pulse (
        .clock(clock),
        .rst_n(rst_n),
        .ce(ce),
        .osc_in_pin(pins_i.osc_in_pin),
        .clr(pulse_clr),
        .adv_en(pulse_adv),
        .phase_r(phase),
        .step_r(step)
    );

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            addr_r <= '0;
        end else if (ce) begin
            if (!in_prog || mode_r == MODE_CLEAR) begin
                addr_r <= '0;
            end else if (step) begin
                addr_r <= addr_r + ADDR_W'(1);
            end
        end
    end

    // ------------------------------------------------------------
    // Program memory
    // ------------------------------------------------------------
    assign mem_we = in_prog && (mode_r == MODE_WRITE);
    assign mem_be = phase[PHASE_HALF_BIT] ? BE_HIGH : BE_LOW;

    otp_mem #(
        .WORDS(WORDS),
        .DATA_W(MEM_DATA_W),
        .ADDR_W(ADDR_W)
    ) u_mem (
        .clock(clock),
        .ce(ce),
        .we(mem_we),
        .be(mem_be),
        .addr(addr_r),
        .wdata({pins_i.data_in, pins_i.data_in}),
        .rdata_r(mem_rdata)
    );

    // ------------------------------------------------------------
    // Pin drive
    // ------------------------------------------------------------
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            pins_r <= '0;
        end else if (ce) begin
            case (sess_r)
                S_PROG: begin
                    pins_r.port_ob_out <= '0;
                    pins_r.port_ob_oe <= '0;
                    if (mode_r == MODE_VERIFY) begin
                        pins_r.data_oe <= '1;
                        pins_r.data_out <= phase[PHASE_HALF_BIT]
                            ? mem_rdata[MEM_DATA_W-1:PIN_DATA_W]
                            : mem_rdata[PIN_DATA_W-1:0];
                    end else begin
                        pins_r.data_oe <= '0;
                        pins_r.data_out <= '0;
                    end
                end
                S_NORMAL: begin
                    pins_r <= core_pins_i;
                end
                default: begin
                    pins_r <= '0;
                end
            endcase
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            prog_active_r <= 1'b0;
        end else if (ce) begin
            prog_active_r <= in_prog;
        end
    end

    // ------------------------------------------------------------
    // Write attempt counter
    // ------------------------------------------------------------
    assign wr_entry = (mode_r == MODE_WRITE) && (mode_prev_r != MODE_WRITE);
    assign wrcnt_clr = bus_done && avs_write && (avs_address == REG_WRCNT);

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            wrcnt_r <= '0;
        end else if (ce) begin
            if (wrcnt_clr) begin
                wrcnt_r <= WRCNT_W'(wr_entry);
            end else if (wr_entry) begin
                wrcnt_r <= wrcnt_r + WRCNT_W'(1);
            end
        end
    end

    // ------------------------------------------------------------
    // Avalon-MM slave
    // ------------------------------------------------------------
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            allow_r <= CTRL_ALLOW_RST;
        end else if (ce) begin
            if (bus_done && avs_write && avs_address == REG_CTRL) begin
                allow_r <= avs_writedata[CTRL_ALLOW_BIT];
            end
        end
    end

    // One wait cycle, then the answer for one cycle
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            waitreq_r <= 1'b1;
            rdata_r <= '0;
        end else if (ce) begin
            if (bus_req && waitreq_r) begin
                waitreq_r <= 1'b0;
                case (avs_address)
                    REG_CTRL: rdata_r <= {31'h00000000, allow_r};
                    REG_STATUS: rdata_r <= {7'h00, addr_r, 6'h00, phase,
                                            2'h0, mode_r, in_prog};
                    REG_WRCNT: rdata_r <= {16'h0000, wrcnt_r};
                    default: rdata_r <= '0;
                endcase
            end else begin
                waitreq_r <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign avs_waitrequest = waitreq_r;
    assign avs_readdata = rdata_r;
    assign pins_o = pins_r;
    assign prog_active = prog_active_r;

endmodule : otp_prog_top
`default_nettype wire

// file: sim/otp_prog_asserts.sv
// Checker for the OTP write/verify block, bound to its top module.
// Assumes ce is low only while the bus is idle; pins synchronous to clock.
`timescale 1ns/1ps
`default_nettype none
module otp_prog_asserts
    import otp_pkg::*;
#(
    parameter int unsigned WORDS = MEM_WORDS,
    parameter int unsigned ADDR_W = MEM_ADDR_W
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // Register bus
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic avs_waitrequest,
    // Device pins
    input wire otp_pin_in_s pins_i,
    input wire otp_pin_out_s pins_o,
    input wire logic prog_active
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    // ----------------------------------------
    // Mode windows
    // ----------------------------------------
    sequence s_verify;
        (prog_active && pins_i.mode_sel == PAT_VERIFY) [*4];
    endsequence
    sequence s_other;
        (prog_active && pins_i.mode_sel != PAT_VERIFY) [*4];
    endsequence

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    a_wait_one: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("bus request not answered after one wait cycle");
    a_wait_pulse: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("waitrequest low for more than one cycle");
    a_verify_drive: assert property (s_verify |-> pins_o.data_oe == 8'hFF)
        else $error("data pins not driven in verify");
    a_write_float: assert property (s_other |-> pins_o.data_oe == 8'h00)
        else $error("data pins driven outside verify");
    a_ob_input: assert property (prog_active && $past(prog_active) && $past(pins_i.vpp_prog)
        |-> pins_o.port_ob_oe == 3'h0)
        else $error("mode pins driven during write/verify");
    a_vpp_held: assert property (prog_active
        |-> $past(pins_i.vpp_prog, 2) && $past(pins_i.vdd_prog, 2))
        else $error("session active without programming levels");
    a_exit_vpp: assert property (!pins_i.vpp_prog [*3] |-> !prog_active)
        else $error("session kept after programming voltage removed");
    a_exit_reset: assert property (pins_i.rst_pin_low [*3] |-> !prog_active)
        else $error("session kept with reset pin low");

    // ----------------------------------------
    // Covers
    // ----------------------------------------
    c_entry: cover property ($rose(prog_active));
    c_verify: cover property (s_verify);
    c_answer: cover property (avs_read && !avs_waitrequest);
endmodule : otp_prog_asserts
`default_nettype wire

// file: sim/otp_pgm_model.sv
// Behavioural PROM programmer driving the mode, clock, supply and data pins.
// Assumes the bench calls its tasks; data lines rest at the pull-down level.
`timescale 1ns/1ps
`default_nettype none
module otp_pgm_model
    import otp_pkg::*;
#(
    parameter int unsigned WR_CYC = 100000
) (
    // Clock
    input wire logic clock,
    // Pins
    input wire otp_pin_out_s pins_o,
    output var otp_pin_in_s pins_i
);
    logic [MODE_W-1:0] mode = 4'h0;
    logic osc = 1'b0;
    logic rlow = 1'b0;
    logic vpp = 1'b0;
    logic vdd = 1'b0;
    logic drv_en = 1'b0;
    logic [PIN_DATA_W-1:0] drv = 8'h00;
    logic [PIN_DATA_W-1:0] wire_d;

    // Released data lines fall to ground
    assign wire_d = (pins_o.data_oe & pins_o.data_out) | (~pins_o.data_oe & (drv_en ? drv : 8'h00));
    assign pins_i = '{mode, osc, rlow, vpp, vdd, wire_d};

    task automatic cyc(input int n);
        repeat (n) @(posedge clock);
    endtask : cyc

    task automatic setm(input logic [MODE_W-1:0] m);
        @(posedge clock);
        mode <= m;
        cyc(4);
    endtask : setm

    task automatic pulse(input int n);
        repeat (n) begin
            @(posedge clock);
            osc <= 1'b1;
            cyc(2);
            osc <= 1'b0;
            cyc(1);
        end
        cyc(4);
    endtask : pulse

    task automatic enter();
        @(posedge clock);
        mode <= 4'h0;
        osc <= 1'b0;
        rlow <= 1'b1;
        cyc(RESET_HOLD_CYC + 8);
        rlow <= 1'b0;
        setm(PAT_CLEAR);
        @(posedge clock);
        vdd <= 1'b1;
        vpp <= 1'b1;
        cyc(4);
        setm(PAT_INHIBIT);
    endtask : enter

    task automatic leave();
        setm(PAT_CLEAR);
        @(posedge clock);
        vdd <= 1'b0;
        vpp <= 1'b0;
        cyc(4);
    endtask : leave

    task automatic half(input logic [7:0] b, output int tries);
        logic ok;
        tries = 0;
        ok = 1'b0;
        while (!ok && tries < 4) begin
            tries++;
            @(posedge clock);
            drv <= b;
            drv_en <= 1'b1;
            setm(PAT_WRITE);
            cyc(WR_CYC);
            setm(PAT_INHIBIT);
            @(posedge clock);
            drv_en <= 1'b0;
            setm(PAT_VERIFY);
            cyc(6);
            ok = (wire_d === b);
            setm(PAT_INHIBIT);
        end
        @(posedge clock);
        drv_en <= 1'b1;
        setm(PAT_WRITE);
        cyc(tries * WR_CYC);
        setm(PAT_INHIBIT);
        @(posedge clock);
        drv_en <= 1'b0;
    endtask : half

    task automatic word(input logic [15:0] w, output int t_lo, output int t_hi);
        half(w[7:0], t_lo);
        pulse(2);
        half(w[15:8], t_hi);
        pulse(2);
    endtask : word
endmodule : otp_pgm_model
`default_nettype wire

// file: sim/otp_prog_tb_top.sv
// Self-checking bench: bus tasks, programmer model and the block under test.
// Assumes a 100 MHz clock and a 16 cycle reset at start.
`timescale 1ns/1ps
`default_nettype none
module otp_prog_tb_top
    import otp_pkg::*;
;
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic [AVS_ADDR_W-1:0] avs_address = 4'h0;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    otp_pin_in_s pins_i;
    otp_pin_out_s pins_o;
    otp_pin_out_s core_pins_i = '{3'h5, 3'h3, 8'hC3, 8'h0F};
    logic ce = 1'b1;
    logic prog_active;
    int error_cnt = 0;
    int total_checks = 0;
    int t0;
    int t1;
    logic [15:0] words [3] = '{16'hA55A, 16'h0FF0, 16'h1234};
    logic [3:0] pats [6] = '{PAT_CLEAR, PAT_VERIFY, PAT_INHIBIT, 4'hF, 4'h0, PAT_WRITE};
    logic [4:0] ohs [6] = '{5'h02, 5'h08, 5'h10, 5'h10, 5'h01, 5'h04};

    always #5 clock = ~clock;

    otp_prog_top i_dut (.clock(clock), .rst_n(rst_n), .ce(ce), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .pins_i(pins_i),
        .pins_o(pins_o), .core_pins_i(core_pins_i), .prog_active(prog_active));
    otp_pgm_model #(.WR_CYC(20)) i_pgm (.clock(clock), .pins_o(pins_o), .pins_i(pins_i));

    task automatic final_report();
        if (error_cnt == 0 && total_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : final_report

    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        total_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: %s got %h expected %h", $time, what, seen, exp);
        end
    endtask : check

    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d,
        output logic [31:0] q);
        int n;
        n = 0;
        @(posedge clock);
        avs_address <= a;
        avs_writedata <= d;
        avs_read <= !wr;
        avs_write <= wr;
        do begin
            @(posedge clock);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 50);
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        check(32'(n < 50), 32'h1, "bus answer");
        if (n >= 50) begin
            final_report();
        end
    endtask : bus

    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask : wr

    task automatic rd_chk(input logic [3:0] a, input logic [31:0] m, input logic [31:0] e,
        input string what);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, q);
        check(q & m, e, what);
    endtask : rd_chk

    initial begin
        #300000;
        error_cnt++;
        final_report();
    end

    initial begin
        repeat (16) @(posedge clock);
        rst_n <= 1'b1;
        rd_chk(REG_CTRL, 32'hFFFFFFFF, 32'h1, "ctrl reset");
        rd_chk(REG_WRCNT, 32'hFFFFFFFF, 32'h0, "count reset");
        wr(4'hC, 32'hFFFFFFFF);
        rd_chk(4'hC, 32'hFFFFFFFF, 32'h0, "unmapped");
        wr(REG_STATUS, 32'hFFFFFFFF);
        rd_chk(REG_STATUS, 32'h1, 32'h0, "status read only");
        wr(REG_CTRL, 32'h0);
        i_pgm.enter();
        check(32'(prog_active), 32'h0, "entry blocked");
        i_pgm.leave();
        wr(REG_CTRL, 32'h1);
        i_pgm.enter();
        check(32'(prog_active), 32'h1, "entry");
        for (int i = 0; i < 6; i++) begin
            i_pgm.setm(pats[i]);
            rd_chk(REG_STATUS, 32'h3F, {26'h0, ohs[i], 1'b1}, "mode decode");
        end
        rd_chk(REG_WRCNT, 32'hFFFF, 32'h1, "write entries");
        wr(REG_WRCNT, 32'h0);
        rd_chk(REG_WRCNT, 32'hFFFF, 32'h0, "count cleared");
        i_pgm.pulse(3);
        rd_chk(REG_STATUS, 32'h01FF0300, 32'h00000300, "write pulses");
        i_pgm.setm(4'h0);
        i_pgm.pulse(1);
        rd_chk(REG_STATUS, 32'h01FF0300, 32'h0, "idle pulses");
        i_pgm.setm(PAT_INHIBIT);
        i_pgm.pulse(4);
        rd_chk(REG_STATUS, 32'h01FF0300, 32'h00010000, "inhibit step");
        i_pgm.setm(PAT_CLEAR);
        rd_chk(REG_STATUS, 32'h01FF0300, 32'h0, "address clear");
        i_pgm.setm(PAT_INHIBIT);
        for (int i = 0; i < 3; i++) begin
            i_pgm.word(words[i], t0, t1);
            check(32'(t0), 32'h1, "low byte tries");
            check(32'(t1), 32'h1, "high byte tries");
        end
        rd_chk(REG_STATUS, 32'h01FF0000, 32'h00030000, "address after write");
        rd_chk(REG_WRCNT, 32'hFFFF, 32'hC, "write entries");
        // Step on to the last word, program it, address wraps
        i_pgm.pulse(2032);
        i_pgm.word(16'hC33C, t0, t1);
        check(32'(t0 + t1), 32'h2, "last word tries");
        rd_chk(REG_STATUS, 32'h01FF0000, 32'h0, "address wrap");
        i_pgm.setm(PAT_CLEAR);
        i_pgm.setm(PAT_INHIBIT);
        i_pgm.setm(PAT_VERIFY);
        for (int i = 0; i < 3; i++) begin
            for (int h = 0; h < 2; h++) begin
                i_pgm.cyc(6);
                check(32'(pins_o.data_out), 32'(h != 0 ? words[i][15:8] : words[i][7:0]),
                    "verify byte");
                check(32'(pins_o.data_oe), 32'hFF, "verify drive");
                i_pgm.pulse(2);
            end
        end
        rd_chk(REG_STATUS, 32'h01FF0000, 32'h00030000, "address after verify");
        i_pgm.leave();
        check(32'(prog_active), 32'h0, "exit");
        check(32'(pins_o), 32'(core_pins_i), "normal pins");
        ce <= 1'b0;
        core_pins_i <= '{3'h2, 3'h4, 8'h3C, 8'hF0};
        i_pgm.cyc(3);
        check(32'(pins_o), 32'({3'h5, 3'h3, 8'hC3, 8'h0F}), "frozen pins");
        ce <= 1'b1;
        i_pgm.cyc(3);
        check(32'(pins_o), 32'({3'h2, 3'h4, 8'h3C, 8'hF0}), "pins after thaw");
        final_report();
    end
endmodule : otp_prog_tb_top

bind otp_prog_top otp_prog_asserts #(.WORDS(WORDS), .ADDR_W(ADDR_W)) i_chk (.clock(clock),
    .rst_n(rst_n), .avs_read(avs_read), .avs_write(avs_write),
    .avs_waitrequest(avs_waitrequest), .pins_i(pins_i), .pins_o(pins_o),
    .prog_active(prog_active));
`default_nettype wire
